// [ssmd_assertions.sv]
// Checker for the serial master's bus handshakes and pins.
// Bound to ssmd_top; it sees that module's ports only.
`timescale 1ns/1ps
module ssmd_assertions (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Bus handshakes
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	// Pins
	input wire logic sck_o,
	input wire logic sdo_oe,
	input wire logic irq
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Reset checks keep running while reset is held
	a_oe_reset_low: assert property (
		disable iff (1'b0) !aresetn |=> !sdo_oe)
		else $error("data pin driven in reset");
	a_sck_irq_idle: assert property (
		disable iff (1'b0) !aresetn |=> sck_o && !irq)
		else $error("clock or irq wrong in reset");
	// Pin enable follows a register write
	a_oe_rise_write: assert property (
		$rose(sdo_oe) |-> s_axi_bvalid)
		else $error("pin driven without write");
	a_oe_fall_write: assert property (
		$fell(sdo_oe) && $past(aresetn) |-> s_axi_bvalid)
		else $error("pin released without write");
	// Answers hold until taken
	a_bvalid_holds: assert property (
		s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	a_rvalid_holds: assert property (
		s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped");
	a_read_blocks: assert property (
		s_axi_rvalid |-> !s_axi_arready)
		else $error("read accepted while answering");
	a_write_blocks: assert property (
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted while answering");
	c_irq: cover property ($rose(irq));
	c_oe_off: cover property ($fell(sdo_oe));
	c_sck: cover property ($fell(sck_o));
endmodule

// [ssmd_pkg.sv]
// Package of the duplex clock-synchronous serial master.
// Assumes a 40 MHz system clock and 32-bit AXI4-Lite register access.
package ssmd_pkg;
	// Clock and serial rate
	localparam int CLK_HZ = 40_000_000;
	localparam int BIT_RATE_HZ = 100_000;
	// Half-bit count minus one, from the rate
	localparam int DIV_CALC = CLK_HZ / (2 * BIT_RATE_HZ) - 1;
	localparam logic [7:0] DIV_RESET = DIV_CALC[7:0];
	// Character length
	localparam int CHAR_BITS = 8;
	localparam logic [2:0] LAST_BIT = 3'h7;

	// Register byte addresses
	localparam logic [4:0] ADDR_CTRL = 5'h00;
	localparam logic [4:0] ADDR_STATUS = 5'h04;
	localparam logic [4:0] ADDR_MASK = 5'h08;
	localparam logic [4:0] ADDR_TXDATA = 5'h0C;
	localparam logic [4:0] ADDR_RXDATA = 5'h10;
	localparam logic [4:0] ADDR_DIV = 5'h14;

	// Control fields
	localparam int C_TX_EN = 0;
	localparam int C_RX_EN = 1;
	localparam int C_TX_IRQ_EN = 2;
	localparam int C_RX_IRQ_EN = 3;
	localparam int C_TEND_IRQ_EN = 4;
	localparam int C_MSB_FIRST = 5;
	localparam logic [5:0] CTRL_RESET = 6'h00;

	// Status fields, also the mask layout
	localparam int S_TX_EMPTY = 0;
	localparam int S_TX_END = 1;
	localparam int S_RX_FULL = 2;
	localparam int S_RX_ERROR = 3;
	localparam logic [3:0] FLAGS_RESET = 4'h0;

	// Bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Shifter states, one-hot
	typedef enum logic [1:0] {
		SH_IDLE = 2'b01,
		SH_RUN = 2'b10
	} ssmd_sh_t;
endpackage

// [ssmd_slave_model.sv]
// Behavioural slave at the far end of the serial link.
// Assumes the master samples on rising clock and shifts on falling.
`timescale 1ns/1ps
module ssmd_slave_model (
	// Link pins
	input wire logic sck,
	input wire logic sdo,
	output logic sdi,
	// Bench side
	input wire logic en,
	input wire logic msb,
	input wire logic [7:0] tx,
	output logic [7:0] got
);
	int n = 0; // Bit count in the frame
	initial sdi = 1'b0;
	always @(negedge sck) begin
		if (en)
			sdi = msb ? tx[3'(7 - n)] : tx[3'(n)];
	end
	always @(posedge sck) begin
		if (en) begin
			got = msb ? {got[6:0], sdo} : {sdo, got[7:1]};
			n = (n + 1) % 8;
			// Idle line must not look like a held bit
			if (n == 0)
				sdi = ~sdi;
		end
	end
endmodule

// [ssmd_top.sv]
// Duplex clock-synchronous serial master with AXI4-Lite registers.
// Assumes a slave that samples on the rising serial clock edge and a
// data-in pin that is asynchronous to aclk.
//
// The register offsets and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
module ssmd_top import ssmd_pkg::*; #(
	parameter logic [7:0] DIV_DEFAULT = DIV_RESET
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Write address
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// Write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// Write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// Read address
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// Read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Serial pins
	output logic sck_o,
	output logic sdo_o,
	output logic sdo_oe,
	input wire logic sdi_i,
	// Interrupt
	output logic irq
);

	// Whole module state
	typedef struct packed {
		// Bus side
		logic aw_have;
		logic [4:0] aw_addr;
		logic w_have;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		// Registers
		logic [5:0] ctrl;
		logic [3:0] flags;
		logic [3:0] mask;
		logic [7:0] div;
		logic [7:0] tx_buf;
		logic tx_full;
		logic [7:0] rx_buf;
		logic rx_hold;
		// Shifter
		ssmd_sh_t sh;
		logic [7:0] cnt;
		logic [2:0] bitn;
		logic [7:0] tx_sh;
		logic [7:0] rx_sh;
		logic do_rx;
		// Pin input synchroniser, filtered level
		logic [2:0] sync;
		logic sdi;
		// Pins and interrupt
		logic sck;
		logic sdo;
		logic irq;
	} ssmd_state_t;

	ssmd_state_t q; // Registered state
	ssmd_state_t d; // Next state

	// Next-state logic for bus, registers and shifter
	always_comb begin
		logic [3:0] set_f;     // Hardware flag sets this cycle
		logic [3:0] clr_f;     // Software write-one clears
		logic [3:0] gate;      // Request enables per source
		logic tick;            // Half-bit enable from divider
		logic msb;             // Bit order
		logic [31:0] rd;       // Read mux
		logic rd_ok;           // Read address mapped
		logic wr_ok;           // Write address mapped
		logic start;           // Begin a character
		logic sdi_f;           // Pin level agreed this cycle
		d = q;
		set_f = 4'h0;
		clr_f = 4'h0;
		rd = 32'h0000_0000;
		rd_ok = 1'b1;
		wr_ok = 1'b1;
		msb = q.ctrl[C_MSB_FIRST];
		gate = 4'h0;
		start = 1'b0;
		sdi_f = q.sdi;
		tick = (q.cnt == q.div);

		// Three-stage pin sampler; a change counts once the last two stages agree
		d.sync = {q.sync[1:0], sdi_i};
		// Agreed level used at once: with four-cycle half bits the
		// registered copy would still show the bit before
		if (q.sync[2] == q.sync[1]) begin
			sdi_f = q.sync[2];
		end
		d.sdi = sdi_f;

		// Take write address and data in either order
		if (s_axi_awvalid && q.awready) begin
			d.aw_have = 1'b1;
			d.aw_addr = s_axi_awaddr[4:0];
		end
		if (s_axi_wvalid && q.wready) begin
			d.w_have = 1'b1;
			d.w_data = s_axi_wdata;
			d.w_strb = s_axi_wstrb;
		end

		// Register write once both halves are held
		if (q.aw_have && q.w_have && !q.bvalid) begin
			d.aw_have = 1'b0;
			d.w_have = 1'b0;
			d.bvalid = 1'b1;
			if (q.w_strb[0]) begin
				case (q.aw_addr)
					ADDR_CTRL: begin
						d.ctrl = q.w_data[5:0];
						if (q.w_data[C_TX_EN] && !q.ctrl[C_TX_EN]
						    && !q.tx_full) begin
							set_f[S_TX_EMPTY] = 1'b1;
						end
					end
					ADDR_STATUS: clr_f = q.w_data[3:0];
					ADDR_MASK: d.mask = q.w_data[3:0];
					ADDR_TXDATA: begin
						// Loading clears the empty flag
						d.tx_buf = q.w_data[7:0];
						d.tx_full = 1'b1;
						clr_f[S_TX_EMPTY] = 1'b1;
					end
					ADDR_DIV: d.div = q.w_data[7:0];
					ADDR_RXDATA: wr_ok = 1'b1;
					default: wr_ok = 1'b0;
				endcase
			end else begin
				// No low byte lane: mapped check only
				case (q.aw_addr)
					ADDR_CTRL, ADDR_STATUS, ADDR_MASK,
					ADDR_TXDATA, ADDR_RXDATA, ADDR_DIV: wr_ok = 1'b1;
					default: wr_ok = 1'b0;
				endcase
			end
			d.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (q.bvalid && s_axi_bready) begin
			d.bvalid = 1'b0;
		end

		// Read: one cycle from address to data
		case (s_axi_araddr[4:0])
			ADDR_CTRL: rd = {26'h000_0000, q.ctrl};
			ADDR_STATUS: rd = {25'h000_0000, q.rx_hold, q.tx_full,
			                   (q.sh == SH_RUN), q.flags};
			ADDR_MASK: rd = {28'h000_0000, q.mask};
			ADDR_TXDATA: rd = {24'h00_0000, q.tx_buf};
			ADDR_RXDATA: rd = {24'h00_0000, q.rx_buf};
			ADDR_DIV: rd = {24'h00_0000, q.div};
			default: rd_ok = 1'b0;
		endcase
		if (s_axi_arvalid && q.arready) begin
			d.rvalid = 1'b1;
			d.rdata = rd_ok ? rd : 32'h0000_0000;
			d.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
			// Reading the buffer frees it for the next character
			if (s_axi_araddr[4:0] == ADDR_RXDATA) begin
				d.rx_hold = 1'b0;
			end
		end else if (q.rvalid && s_axi_rready) begin
			d.rvalid = 1'b0;
		end

		// Divider runs only inside a character
		d.cnt = (tick || q.sh == SH_IDLE) ? 8'h00 : q.cnt + 8'h01;

		// Start when a byte waits, or receive-only with buffer free
		start = (q.ctrl[C_TX_EN] && q.tx_full)
		     || (!q.ctrl[C_TX_EN] && q.ctrl[C_RX_EN] && !q.rx_hold);

		// Shifter
		case (q.sh)
			SH_IDLE: begin
				d.sck = 1'b1;
				if (start) begin
					d.sh = SH_RUN;
					d.bitn = 3'h0;
					d.do_rx = q.ctrl[C_RX_EN];
					d.tx_sh = q.ctrl[C_TX_EN] ? q.tx_buf : 8'hFF;
					if (q.ctrl[C_TX_EN]) begin
						// Byte moved to shifter: buffer empty again
						d.tx_full = 1'b0;
						set_f[S_TX_EMPTY] = 1'b1;
					end
				end
			end
			SH_RUN: begin
				if (!q.ctrl[C_TX_EN] && !q.ctrl[C_RX_EN]) begin
					// Both enables dropped: abandon the character
					d.sh = SH_IDLE;
					d.sck = 1'b1;
				end else if (tick && q.sck) begin
					d.sck = 1'b0;
					d.sdo = msb ? q.tx_sh[7] : q.tx_sh[0];
				end else if (tick) begin
					d.sck = 1'b1;
					d.tx_sh = msb ? {q.tx_sh[6:0], 1'b1}
					              : {1'b1, q.tx_sh[7:1]};
					d.rx_sh = msb ? {q.rx_sh[6:0], sdi_f}
					              : {sdi_f, q.rx_sh[7:1]};
					d.bitn = q.bitn + 3'h1;
					if (q.bitn == LAST_BIT) begin
						d.sh = SH_IDLE;
						if (q.do_rx && q.rx_hold) begin
							set_f[S_RX_ERROR] = 1'b1;
						end else if (q.do_rx) begin
							d.rx_buf = msb ? {q.rx_sh[6:0], sdi_f}
							               : {sdi_f, q.rx_sh[7:1]};
							d.rx_hold = 1'b1;
							set_f[S_RX_FULL] = 1'b1;
						end
						if (!(q.ctrl[C_TX_EN] && d.tx_full)) begin
							set_f[S_TX_END] = q.ctrl[C_TX_EN];
						end
					end
				end
			end
			default: d.sh = SH_IDLE;
		endcase

		// Leaving transmit drops the end flag
		if (q.ctrl[C_TX_EN] && !d.ctrl[C_TX_EN]) begin
			clr_f[S_TX_END] = 1'b1;
		end

		// sticky flags, set wins over clear
		d.flags = (q.flags & ~clr_f) | set_f;

		gate[S_TX_EMPTY] = q.ctrl[C_TX_IRQ_EN];
		gate[S_TX_END] = q.ctrl[C_TEND_IRQ_EN];
		gate[S_RX_FULL] = q.ctrl[C_RX_IRQ_EN];
		gate[S_RX_ERROR] = q.ctrl[C_RX_IRQ_EN];
		d.irq = |(q.flags & q.mask & gate);

		// Ready flags: one write and one read at a time
		d.awready = !d.aw_have && !d.bvalid;
		d.wready = !d.w_have && !d.bvalid;
		d.arready = !d.rvalid;
	end

	// State register, synchronous reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
			q.ctrl <= CTRL_RESET;
			q.flags <= FLAGS_RESET;
			q.mask <= FLAGS_RESET;
			q.div <= DIV_DEFAULT;
			q.sh <= SH_IDLE;
			q.sync <= 3'h7;
			q.sdi <= 1'b1;
			q.sck <= 1'b1;
			q.sdo <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// Outputs straight from state flops
	assign s_axi_awready = q.awready;
	assign s_axi_wready = q.wready;
	assign s_axi_bvalid = q.bvalid;
	assign s_axi_bresp = q.bresp;
	assign s_axi_arready = q.arready;
	assign s_axi_rvalid = q.rvalid;
	assign s_axi_rdata = q.rdata;
	assign s_axi_rresp = q.rresp;
	assign sck_o = q.sck;
	assign sdo_o = q.sdo;
	// pin driven only with transmit enabled
	assign sdo_oe = q.ctrl[C_TX_EN];
	assign irq = q.irq;

endmodule

// [test_sync_serial_master_duplex.sv]
// Bench of the duplex serial master: bus tasks, slave, read queue.
// Assumes the package, design, checker and slave are compiled first.
`timescale 1ns/1ps
module test_sync_serial_master_duplex import ssmd_pkg::*; ;
	// Expected read: value, compared bits, response
	typedef struct packed {
		logic [31:0] d;
		logic [31:0] m;
		logic [1:0] r;
	} ssmd_exp_t;
	logic aclk = 0, aresetn = 0, sdi, s_msb = 0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid, sck, sdo, sdo_oe, irq;
	logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata;
	logic [1:0] bresp, rresp;
	logic [7:0] s_tx = 0, s_got, txb, sv, held;
	ssmd_exp_t q[$]; // Expected reads, oldest first
	ssmd_exp_t ex;
	int failures = 0, checks_done = 0, i;
	ssmd_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .sck_o(sck), .sdo_o(sdo), .sdo_oe(sdo_oe),
		.sdi_i(sdi), .irq(irq));
	ssmd_slave_model slave (.sck(sck), .sdo(sdo), .sdi(sdi), .en(aresetn),
		.msb(s_msb), .tx(s_tx), .got(s_got));
	initial forever #12.5 aclk = ~aclk;
	// Read watcher takes the oldest note
	always @(posedge aclk) begin
		if (rvalid && rready) begin
			ex = q.pop_front();
			cmp_rd(ex);
		end
	end
	task automatic cmp_rd(input ssmd_exp_t e);
		checks_done++;
		if ((rdata & e.m) !== e.d || rresp !== e.r) begin
			failures++;
			$display("mismatch at %0t: read %h exp %h", $time, rdata, e.d);
		end
	endtask
	task automatic cmp_pin(input logic [7:0] g, input logic [7:0] e);
		checks_done++;
		if (g !== e) begin
			failures++;
			$display("mismatch at %0t: pins %h exp %h", $time, g, e);
		end
	endtask
	// Write answer code, taken at the bvalid edge
	task automatic cmp_resp(input logic [1:0] g, input logic [1:0] e);
		checks_done++;
		if (g !== e) begin
			failures++;
			$display("mismatch at %0t: resp %h exp %h", $time, g, e);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic tmo();
		failures++;
		$display("mismatch at %0t: wait ran out", $time);
		end_sim();
	endtask
	// Write: address and data offered together, each released when taken
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		int k;
		@(posedge aclk);
		awaddr <= {27'h000_0000, a};
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (k = 0; k < 64; k++) begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		bready <= 1'b0;
		if (k == 64) tmo();
		cmp_resp(bresp, RESP_OKAY);
	endtask
	task automatic rd(input logic [4:0] a, input logic [31:0] d, m,
		input logic [1:0] r);
		int k;
		q.push_back('{d, m, r});
		@(posedge aclk);
		araddr <= {27'h000_0000, a};
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (k = 0; k < 64; k++) begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		rready <= 1'b0;
		if (k == 64) tmo();
	endtask
	task automatic wait_irq();
		int k;
		for (k = 0; k < 400 && irq !== 1'b1; k++) @(posedge aclk);
		if (k == 400) tmo();
	endtask
	initial begin
		void'($urandom(45800));
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		rd(ADDR_CTRL, 32'h0000_0000, 32'hFFFF_FFFF, RESP_OKAY);
		cmp_pin({7'h00, sdo_oe}, 8'h00);
		wr(ADDR_DIV, 32'h0000_0003);
		wr(ADDR_MASK, 32'h0000_0001);
		wr(ADDR_CTRL, 32'h0000_0005);
		rd(ADDR_STATUS, 32'h0000_0001, 32'h0000_000F, RESP_OKAY);
		cmp_pin({6'h00, sdo_oe, irq}, 8'h03);
		wr(ADDR_CTRL, 32'h0000_0001);
		repeat (2) @(posedge aclk);
		cmp_pin({7'h00, irq}, 8'h00);
		$display("test enable done");
		wr(ADDR_MASK, 32'h0000_000C);
		// Third byte lands on an unread buffer
		for (i = 0; i < 3; i++) begin
			txb = 8'($urandom);
			sv = 8'($urandom);
			s_tx <= sv;
			s_msb <= i[0];
			if (i < 2) held = sv;
			wr(ADDR_STATUS, 32'h0000_000F);
			wr(ADDR_CTRL, {26'h000_0000, i[0], 5'h0B});
			wr(ADDR_TXDATA, {24'h00_0000, txb});
			wait_irq();
			rd(ADDR_STATUS, i == 2 ? 32'h0000_000B : 32'h0000_0007,
				32'h0000_000F, RESP_OKAY);
			cmp_pin(s_got, txb);
			if (i != 1) rd(ADDR_RXDATA, {24'h00_0000, held}, 32'hFFFF_FFFF, RESP_OKAY);
		end
		$display("test duplex done");
		// End flag still set from the last byte: its own gate
		wr(ADDR_MASK, 32'h0000_0002);
		wr(ADDR_CTRL, 32'h0000_0013);
		repeat (2) @(posedge aclk);
		cmp_pin({7'h00, irq}, 8'h01);
		wr(ADDR_CTRL, 32'h0000_0000);
		wr(ADDR_MASK, 32'h0000_0000);
		cmp_pin({6'h00, sdo_oe, irq}, 8'h00);
		rd(ADDR_STATUS, 32'h0000_0000, 32'h0000_0002, RESP_OKAY);
		rd(5'h1C, 32'h0000_0000, 32'hFFFF_FFFF, RESP_SLVERR);
		@(posedge aclk);
		$display("test stop done");
		end_sim();
	end
endmodule
bind ssmd_top ssmd_assertions chk (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_bresp(s_axi_bresp), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.s_axi_rdata(s_axi_rdata), .sck_o(sck_o), .sdo_oe(sdo_oe), .irq(irq));
